// file: rtl/eer_dev.sv
// Summary of operation
// - address pointer never carries into chip-select bits
// - byte write: control, two address, data, acked
// - stop starts write cycle; no acks meanwhile
// - protected write acked, not stored, instantly ready
// - after byte write pointer holds next location
// - page write buffers bytes, commits after stop
// - only five low pointer bits increment, rolling
// - page writes wrap within the same page
// - master must not cross page end
// - protect input high protects whole array
// - protect input sampled at stop of write
// - master polls with write control until acked
// - idle device acknowledges polling control byte
// - current read returns last address plus one
// - read control acked, then byte shifted out
// - random read loads pointer before repeated start
// - after random read pointer holds next location
// - master ack continues with next sequential byte
// - master ends read with nack then stop
// - read pointer wraps from top to zero
// - respond only to matching code and selects
// - thirteen address bits used, top three ignored
// - on master nack device releases data line
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// three-stage input filter, change accepted when last two stages agree
// ---------------------------------------------------------------------
module eer_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;  // first stage, read only by s2
  logic [W-1:0] s2;  // second stage
  logic [W-1:0] s3;  // third stage

  // shift chain and agreement filter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      dout <= INIT;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & dout);
    end
  end
endmodule // eer_sync

// ---------------------------------------------------------------------
// eeprom end of the link
// ---------------------------------------------------------------------
module eer_dev
  import eer_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DEF  // self-timed write length
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  eer_bus_if.dev    bus,
  input  wire logic wp,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  output logic      write_busy
);
  import eer_pkg::*;

  // -------------------------------------------------------------------
  // pin sampling and bus condition detection
  // -------------------------------------------------------------------
  logic [5:0]        sync_q;     // filtered pins
  logic              scl_q;      // previous clock level
  logic              sda_q;      // previous data level
  wire  logic        scl_s   = sync_q[0];
  wire  logic        sda_s   = sync_q[1];
  wire  logic        wp_s    = sync_q[2];
  wire  logic [2:0]  cs_s    = sync_q[5:3];
  wire  logic        scl_rise = scl_s & ~scl_q;
  wire  logic        scl_fall = ~scl_s & scl_q;
  wire  logic        start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire  logic        stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  eer_sync #(.W(6), .INIT(6'h03)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     ({chip_select_bit2, chip_select_bit1, chip_select_bit0, wp, bus.sda, bus.scl}),
    .dout    (sync_q)
  );

  // edge history
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  logic [7:0]        mem [0:(1<<ADDR_W)-1];      // 8k x 8 array
  logic [7:0]        pbuf [0:(1<<PAGE_W)-1];     // page buffer
  logic [31:0]       pvalid;                     // buffered byte flags

  // -------------------------------------------------------------------
  // protocol state
  // -------------------------------------------------------------------
  eer_dst_t          state;      // command phase
  logic [3:0]        bitcnt;     // clock rises in current byte
  logic [7:0]        shreg;      // received bits
  logic [7:0]        txreg;      // bits to send
  logic [ADDR_W-1:0] ptr;        // address pointer
  logic [4:0]        hi_addr;    // held high address bits
  logic              sda_oe;     // pull data low
  logic              wr_go;      // start write cycle pulse
  logic              busy;       // write cycle running

  // decode of a completed byte
  wire  logic        byte_done = scl_fall & (bitcnt == ACK_SLOT);
  wire  logic        ack_rise  = scl_rise & (bitcnt == ACK_SLOT);
  wire  logic        ctrl_hit  = (shreg[7:4] == CTRL_CODE) &
                                 (shreg[3:1] == cs_s) & ~busy;
  wire  logic        ctrl_wr   = ctrl_hit & ~shreg[0];
  wire  logic [4:0]  pg_next   = ptr[4:0] + 5'h01;
  wire  logic [ADDR_W-1:0] ptr_next = ptr + 13'h0001;
  wire  logic        has_data  = |pvalid;

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign write_busy     = busy;

  // byte framing, acknowledge and pointer handling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= D_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      txreg   <= 8'h00;
      ptr     <= 13'h0000;
      hi_addr <= 5'h00;
      sda_oe  <= 1'b0;
      wr_go   <= 1'b0;
    end else begin
      wr_go <= 1'b0;
      if (start_det) begin
        // start or repeated start drops any command
        state  <= D_CTRL;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        // stop ending a write launches the cycle unless protected
        if ((state == D_WDAT) && has_data && !wp_s) begin
          wr_go <= 1'b1;
        end
        state  <= D_IDLE;
        sda_oe <= 1'b0;
      end else begin
        // bit counting on clock rises
        if (scl_rise) begin
          if (bitcnt == ACK_SLOT) begin
            bitcnt <= 4'h0;
          end else begin
            bitcnt <= bitcnt + 4'h1;
            shreg  <= {shreg[6:0], sda_s};
          end
        end
        case (state)
          D_IDLE: begin
            sda_oe <= 1'b0;
          end
          D_CTRL: begin
            if (byte_done) begin
              if (ctrl_hit) begin
                sda_oe <= 1'b1;
                if (shreg[0]) begin
                  txreg <= mem[ptr];
                  ptr   <= ptr_next;
                  state <= D_RDAT;
                end else begin
                  state <= D_AHI;
                end
              end else begin
                state <= D_IDLE;
              end
            end
          end
          D_AHI: begin
            if (byte_done) begin
              hi_addr <= shreg[4:0];
              sda_oe  <= 1'b1;
              state   <= D_ALO;
            end else if (scl_fall && bitcnt == 4'h0) begin
              sda_oe <= 1'b0;
            end
          end
          D_ALO: begin
            if (byte_done) begin
              ptr    <= {hi_addr, shreg};
              sda_oe <= 1'b1;
              state  <= D_WDAT;
            end else if (scl_fall && bitcnt == 4'h0) begin
              sda_oe <= 1'b0;
            end
          end
          D_WDAT: begin
            if (byte_done) begin
              sda_oe   <= 1'b1;
              ptr[4:0] <= pg_next;
            end else if (scl_fall && bitcnt == 4'h0) begin
              sda_oe <= 1'b0;
            end
          end
          D_RDAT: begin
            if (scl_fall) begin
              if (bitcnt == ACK_SLOT) begin
                sda_oe <= 1'b0;  // free line for master ack
              end else begin
                sda_oe <= ~txreg[7];
                txreg  <= {txreg[6:0], 1'b0};
              end
            end
            // own ack of the control byte is not a master ack
            if (ack_rise && !sda_oe) begin
              if (!sda_s) begin
                txreg <= mem[ptr];
                ptr   <= ptr_next;
              end else begin
                state <= D_IDLE;
              end
            end
          end
          default: begin
            state  <= D_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // page buffer
  // -------------------------------------------------------------------
  // flags: cleared by a new write command, set per received byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pvalid <= 32'h0000_0000;
    end else if (state == D_CTRL && byte_done && ctrl_wr) begin
      pvalid <= 32'h0000_0000;
    end else if (state == D_WDAT && byte_done && !start_det && !stop_det) begin
      pvalid[ptr[4:0]] <= 1'b1;
    end
  end

  // data: later bytes overwrite earlier ones at the same slot
  always_ff @(posedge ref_clk) begin
    if (state == D_WDAT && byte_done && !start_det && !stop_det) begin
      pbuf[ptr[4:0]] <= shreg;
    end
  end

  // -------------------------------------------------------------------
  // self-timed write cycle
  // -------------------------------------------------------------------
  logic [5:0]  cidx;    // commit slot index
  logic [7:0]  cbase;   // page being committed
  logic [31:0] wcnt;    // cycle timer

  // busy flag and timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy  <= 1'b0;
      cidx  <= 6'h00;
      cbase <= 8'h00;
      wcnt  <= 32'h0000_0000;
    end else if (wr_go) begin
      busy  <= 1'b1;
      cidx  <= 6'h00;
      cbase <= ptr[12:5];
      wcnt  <= 32'h0000_0000;
    end else if (busy) begin
      if (cidx != PAGE_BYTES) begin
        cidx <= cidx + 6'h01;
      end
      if (wcnt == 32'(WR_CYCLES - 1)) begin
        busy <= 1'b0;
      end else begin
        wcnt <= wcnt + 32'h0000_0001;
      end
    end
  end

  // commit buffered bytes into their page
  always_ff @(posedge ref_clk) begin
    if (busy && cidx != PAGE_BYTES && pvalid[cidx[4:0]]) begin
      mem[{cbase, cidx[4:0]}] <= pbuf[cidx[4:0]];
    end
  end
endmodule // eer_dev

// file: rtl/eer_pkg.sv
package eer_pkg;
  // -------------------------------------------------------------------
  // protocol constants
  // -------------------------------------------------------------------
  localparam logic [3:0] CTRL_CODE     = 4'ha;   // device-type code
  localparam int         ADDR_W        = 13;     // array address width
  localparam int         PAGE_W        = 5;      // page offset width
  localparam logic [3:0] ACK_SLOT      = 4'h8;   // ninth clock index
  localparam logic [5:0] PAGE_BYTES    = 6'h20;  // bytes per page
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 8;      // ref_clk period
  localparam int         WR_TIME_NS    = 8000;   // self-timed write time
  localparam int         WR_CYCLES_DEF = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SCL_QTR_DEF   = 8;      // cycles per quarter bit
  localparam int         FIFO_DEPTH    = 8;      // host command fifo depth
  localparam int         CMD_W         = 11;     // op, ack, data
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'h0,  // start, then send byte
    OP_WRITE = 2'h1,  // send byte
    OP_READ  = 2'h2,  // receive byte
    OP_STOP  = 2'h3   // stop condition
  } eer_op_t;
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_CTRL = 6'h02,
    D_AHI  = 6'h04,
    D_ALO  = 6'h08,
    D_WDAT = 6'h10,
    D_RDAT = 6'h20
  } eer_dst_t;
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } eer_hst_t;
endpackage

// file: rtl/eer_bus_if.sv
`timescale 1ns/1ps
interface eer_bus_if;
  // -------------------------------------------------------------------
  // two-wire link, open drain data
  // -------------------------------------------------------------------
  logic scl;          // clock from host
  logic host_sda_o;   // host data output level
  logic host_sda_oe;  // host pulls data low
  logic dev_sda_o;    // device data output level
  logic dev_sda_oe;   // device pulls data low
  logic sda;          // resolved wire level
  // wired-and with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface

// file: rtl/eer_host.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// command fifo
// ---------------------------------------------------------------------
module eer_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] store [0:DEPTH-1];  // entries
  logic [AW:0]  wptr;               // write pointer with wrap bit
  logic [AW:0]  rptr;               // read pointer with wrap bit
  wire  logic   push = in_valid & in_ready;
  wire  logic   pop  = out_valid & out_ready;

  assign in_ready  = ~((wptr[AW] != rptr[AW]) & (wptr[AW-1:0] == rptr[AW-1:0]));
  assign out_valid = (wptr != rptr);
  assign out_data  = store[rptr[AW-1:0]];

  // pointers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end

  // entry write
  always_ff @(posedge ref_clk) begin
    if (push) store[wptr[AW-1:0]] <= in_data;
  end
endmodule // eer_fifo

// ---------------------------------------------------------------------
// bus master end of the link
// ---------------------------------------------------------------------
module eer_host
  import eer_pkg::*;
#(
  parameter int SCL_QTR = SCL_QTR_DEF  // cycles per quarter bit
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  eer_bus_if.host         bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire eer_pkg::eer_op_t cmd_op,
  input  wire logic       cmd_ack,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack
);
  import eer_pkg::*;

  logic              f_valid;  // fifo head present
  logic [CMD_W-1:0]  f_data;   // fifo head
  logic              sda_s;    // filtered data line
  eer_hst_t          state;    // sequencer state
  logic [1:0]        ph;       // quarter-bit phase
  logic [3:0]        bidx;     // bit index in byte
  logic [15:0]       qcnt;     // quarter-bit divider
  logic              scl;      // driven clock
  logic              sda_oe;   // pull data low
  logic              is_read;  // current op receives
  logic              cur_ack;  // ack to give on read
  logic [7:0]        cur_data; // bits to send
  logic [7:0]        shreg;    // bits received
  wire  logic        f_pop = (state == H_IDLE) & f_valid;
  wire  logic        tick  = (qcnt == 16'(SCL_QTR - 1));
  wire  eer_op_t     f_op  = eer_op_t'(f_data[10:9]);

  assign bus.scl         = scl;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe;

  eer_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_op, cmd_ack, cmd_data}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  eer_sync #(.W(1), .INIT(1'b1)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (bus.sda),
    .dout    (sda_s)
  );

  // quarter-bit divider, restarted on each command
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      qcnt <= 16'h0000;
    end else if (state == H_IDLE || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // line sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= H_IDLE;
      ph        <= 2'h0;
      bidx      <= 4'h0;
      scl       <= 1'b1;
      sda_oe    <= 1'b0;
      is_read   <= 1'b0;
      cur_ack   <= 1'b0;
      cur_data  <= 8'h00;
      shreg     <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (tick) ph <= ph + 2'h1;
      case (state)
        H_IDLE: begin
          // take next command; clock stands still meanwhile
          ph <= 2'h0;
          bidx <= 4'h0;
          if (f_valid) begin
            is_read  <= (f_op == OP_READ);
            cur_ack  <= f_data[8];
            cur_data <= f_data[7:0];
            case (f_op)
              OP_START: state <= H_START;
              OP_STOP:  state <= H_STOP;
              default:  state <= H_BIT;
            endcase
          end
        end
        H_START: begin
          // release, raise clock, pull data low, lower clock
          if (tick) begin
            case (ph)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl   <= 1'b0;
                state <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            case (ph)
              2'h0: begin
                if (bidx == ACK_SLOT) begin
                  sda_oe <= is_read & cur_ack;
                end else if (is_read) begin
                  sda_oe <= 1'b0;
                end else begin
                  sda_oe   <= ~cur_data[7];
                  cur_data <= {cur_data[6:0], 1'b0};
                end
              end
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bidx == ACK_SLOT) rsp_nack <= sda_s;
                else shreg <= {shreg[6:0], sda_s};
              end
              default: begin
                scl <= 1'b0;
                if (bidx == ACK_SLOT) begin
                  rsp_valid <= 1'b1;
                  rsp_data  <= shreg;
                  state     <= H_IDLE;
                end else begin
                  bidx <= bidx + 4'h1;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          // data low, clock high, then release data
          if (tick) begin
            case (ph)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl <= 1'b1;
              default: begin
                sda_oe <= 1'b0;
                state  <= H_IDLE;
              end
            endcase
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // eer_host

// file: testbench/eer_assertions.sv
`timescale 1ns/1ps
module eer_assertions #(
  parameter int WR_CYCLES = 2000  // self-timed write length
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic wp,
  input wire logic write_busy
);
  logic [15:0] bcnt;  // length of current busy run
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // count busy cycles, cleared when idle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) bcnt <= 16'h0000;
    else bcnt <= write_busy ? bcnt + 16'h0001 : 16'h0000;
  end
  a_open_drain: assert property (
    !dev_sda_o) else $error("device drives data high");
  a_busy_no_ack: assert property (
    write_busy |-> !dev_sda_oe) else $error("ack during write cycle");
  a_busy_length: assert property (
    $fell(write_busy) |-> bcnt >= WR_CYCLES - 2 && bcnt <= WR_CYCLES + 2)
    else $error("write cycle length wrong");
  a_busy_after_stop: assert property (
    $rose(write_busy) |-> scl && sda) else $error("write cycle before stop");
  a_busy_wp_clear: assert property (
    $rose(write_busy) |-> !wp) else $error("write cycle while protected");
  a_dev_change_low: assert property (
    $changed(dev_sda_oe) |-> !scl) else $error("device data moved with clock high");
  a_dev_hold_high: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("device data unstable");
  a_clk_high_time: assert property (
    $rose(scl) |-> scl [*8]) else $error("clock high too short");
  a_clk_low_time: assert property (
    $fell(scl) |-> !scl [*8]) else $error("clock low too short");
  c_write_cycle: cover property ($rose(write_busy));
  c_start_seen: cover property (scl && $fell(sda));
  c_dev_drives: cover property (dev_sda_oe && scl);
endmodule  // eer_assertions

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import eer_pkg::*;
  logic       ref_clk = 1'b0, arst_n = 1'b0, wp = 1'b0, busy_seen = 1'b0;
  logic [2:0] cs = 3'h0;  // chip select pins
  logic       cmd_valid = 1'b0, cmd_ack = 1'b0;
  eer_op_t    cmd_op = OP_STOP;
  logic [7:0] cmd_data = 8'h00, rsp_data, rq;
  logic       cmd_ready, rsp_valid, rsp_nack, write_busy, rn;
  int         failures = 0, checks = 0, cycles = 0;
  eer_bus_if bus ();
  eer_dev #(.WR_CYCLES(2000)) u_eer_dev (.ref_clk, .arst_n, .bus(bus.dev), .wp,
    .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .write_busy);
  eer_host #(.SCL_QTR(8)) u_eer_host (.ref_clk, .arst_n, .bus(bus.host), .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_ack, .cmd_data, .rsp_valid, .rsp_data, .rsp_nack);
  eer_assertions #(.WR_CYCLES(2000)) u_eer_assertions (.ref_clk, .arst_n, .scl(bus.scl),
    .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .wp, .write_busy);
  always #4 ref_clk = ~ref_clk;
  // cycle ceiling and busy watch
  always @(posedge ref_clk) begin
    cycles++;
    if (write_busy === 1'b1) busy_seen = 1'b1;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // queue one command, valid held until taken
  task automatic push(input eer_op_t op, input logic [7:0] d, input logic a);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask
  task automatic wait_rsp();
    for (int k = 0; k < 4000 && rsp_valid !== 1'b1; k++) @(negedge ref_clk);
    cmp("response", 8'h01, {7'h0, rsp_valid});
    rq = rsp_data;
    rn = rsp_nack;
    @(negedge ref_clk);
  endtask
  // one command to completion; a stop waits for a free bus
  task automatic xfer(input eer_op_t op, input logic [7:0] d, input logic a);
    push(op, d, a);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    if (op != OP_STOP) wait_rsp();
    else begin
      for (int k = 0; k < 400 && !(bus.scl && bus.sda); k++) @(negedge ref_clk);
      cmp("bus free", 8'h01, {7'h0, bus.scl & bus.sda});
      repeat (12) @(negedge ref_clk);
    end
  endtask
  task automatic stop();
    xfer(OP_STOP, 8'h00, 1'b1);
  endtask
  task automatic snd(input eer_op_t op, input logic [7:0] d, input logic n);
    xfer(op, d, 1'b1);
    cmp("nack", {7'h0, n}, {7'h0, rn});
  endtask
  task automatic rrd(input logic [15:0] a);
    snd(OP_START, 8'ha0, 1'b0);
    snd(OP_WRITE, a[15:8], 1'b0);
    snd(OP_WRITE, a[7:0], 1'b0);
  endtask
  task automatic rdb(input logic a, input logic [7:0] e);
    xfer(OP_READ, 8'h00, a);
    cmp("rdata", e, rq);
    cmp("ninth", {7'h0, ~a}, {7'h0, rn});
  endtask
  task automatic pwr(input logic [15:0] a, input logic [31:0] d, input int n);
    rrd(a);
    for (int i = 0; i < n; i++) snd(OP_WRITE, d[31-8*i -: 8], 1'b0);
    stop();
  endtask
  task automatic poll();
    rn = 1'b1;
    for (int i = 0; i < 40 && rn !== 1'b0; i++) begin
      xfer(OP_START, 8'ha0, 1'b1);
      stop();
    end
    cmp("poll", 8'h00, {7'h0, rn});
  endtask
  task automatic s_write_busy();
    pwr(16'h0000, 32'h5aa5_0000, 2);
    for (int k = 0; k < 40 && write_busy !== 1'b1; k++) @(negedge ref_clk);
    wp = 1'b1;
    snd(OP_START, 8'ha1, 1'b1);
    stop();
    snd(OP_START, 8'ha0, 1'b1);
    stop();
    poll();
    wp = 1'b0;
  endtask
  task automatic s_read_wrap();
    pwr(16'hfffe, 32'h1122_3300, 3);
    poll();
    rrd(16'h1ffe);
    snd(OP_START, 8'ha1, 1'b0);
    rdb(1'b1, 8'h11);
    rdb(1'b1, 8'h22);
    rdb(1'b0, 8'h5a);
    stop();
    snd(OP_START, 8'ha1, 1'b0);
    rdb(1'b0, 8'ha5);
    stop();
    rrd(16'h1fe0);
    snd(OP_START, 8'ha1, 1'b0);
    rdb(1'b0, 8'h33);
    stop();
  endtask
  task automatic s_protect();
    wp = 1'b1;
    repeat (8) @(negedge ref_clk);
    busy_seen = 1'b0;
    pwr(16'h0000, 32'h7700_0000, 1);
    snd(OP_START, 8'ha0, 1'b0);
    stop();
    cmp("busy", 8'h00, {7'h0, busy_seen});
    wp = 1'b0;
    rrd(16'h0000);
    snd(OP_START, 8'ha1, 1'b0);
    rdb(1'b0, 8'h5a);
    stop();
  endtask
  task automatic s_select();
    for (int i = 0; i < 8; i++) begin
      cs = i[2:0];
      repeat (8) @(negedge ref_clk);
      snd(OP_START, {4'ha, ~i[2:0], 1'b0}, 1'b1);
      stop();
      snd(OP_START, {4'ha, i[2:0], 1'b0}, 1'b0);
      stop();
    end
    cs = 3'h0;
    repeat (8) @(negedge ref_clk);
    snd(OP_START, 8'hb0, 1'b1);
    stop();
  endtask
  // fill the command queue while the bus is slow
  task automatic s_fifo();
    push(OP_START, 8'ha0, 1'b1);
    push(OP_WRITE, 8'h00, 1'b1);
    push(OP_WRITE, 8'h10, 1'b1);
    for (int i = 1; i < 7; i++) push(OP_WRITE, 8'(i * 17), 1'b1);
    @(negedge ref_clk);
    cmp("ready", 8'h00, {7'h0, cmd_ready});
    cmd_valid = 1'b0;
    for (int i = 0; i < 9; i++) begin
      wait_rsp();
      cmp("nack", 8'h00, {7'h0, rn});
    end
    cmp("ready", 8'h01, {7'h0, cmd_ready});
    stop();
    poll();
    rrd(16'h0015);
    snd(OP_START, 8'ha1, 1'b0);
    rdb(1'b0, 8'h66);
    stop();
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    s_write_busy();
    s_read_wrap();
    s_protect();
    s_select();
    s_fifo();
    final_report();
  end
endmodule  // testbench
